// file: src/iec_top.v
// Prioritised interrupt controller with eight event transfer channels.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/10ps
`include "iec_defines.vh"

module iec_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [`IEC_NODES-1:0] node_req_pulse,
  input wire [`IEC_EXT-1:0] ext_pin,
  input wire [3:0] cpu_level,
  input wire trap_active,
  input wire sw_trap_valid,
  input wire [6:0] sw_trap_num,
  input wire irq_ack,
  output reg irq_req,
  output reg [8:0] irq_vector,
  output reg [3:0] irq_level,
  output reg move_valid,
  output reg [`IEC_AW-1:0] move_src,
  output reg [`IEC_AW-1:0] move_dst,
  output reg move_word,
  output reg irq_out
);

  localparam S_IDLE = 2'd0;
  localparam S_WAIT = 2'd1;
  localparam S_REQ = 2'd2;
  localparam S_MOVE = 2'd3;

  // Trap number of a node from its index.
  function [6:0] trap_of;
    input [4:0] idx;
    begin
      if (idx < `IEC_GRP1_FIRST) begin
        trap_of = `IEC_TRAP_BASE0 + {2'b00, idx};
      end else if (idx < `IEC_GRP2_FIRST) begin
        trap_of = `IEC_TRAP_BASE1 + {2'b00, idx - `IEC_GRP1_FIRST};
      end else begin
        trap_of = `IEC_TRAP_BASE2 + {2'b00, idx - `IEC_GRP2_FIRST};
      end
    end
  endfunction

  // Vector location is the trap number times four.
  function [8:0] vec_of;
    input [6:0] trap;
    begin
      vec_of = {trap, 2'b00};
    end
  endfunction

  reg [`IEC_NODES-1:0] req_r;
  reg [`IEC_NODES-1:0] req_nxt;
  reg [`IEC_NODES-1:0] en_r;
  reg [`IEC_NODES-1:0] evt_r;
  reg [3:0] lvl_r [0:`IEC_NODES-1];
  reg [2:0] chsel_r [0:`IEC_NODES-1];
  reg [`IEC_AW-1:0] src_r [0:`IEC_CHANS-1];
  reg [`IEC_AW-1:0] dst_r [0:`IEC_CHANS-1];
  reg [7:0] cnt_r [0:`IEC_CHANS-1];
  reg [2:0] cctl_r [0:`IEC_CHANS-1];
  reg [15:0] edge_sel_r;
  reg [`IEC_ST_W-1:0] sts_r;
  reg [`IEC_ST_W-1:0] sts_nxt;
  reg [`IEC_ST_W-1:0] mask_r;
  reg [`IEC_EXT-1:0] sync1_r;
  reg [`IEC_EXT-1:0] sync2_r;
  reg [`IEC_EXT-1:0] prev_r;
  reg [1:0] st_r;
  reg [2:0] wait_r;
  reg [4:0] cur_idx_r;
  reg cur_move_r;
  reg [8:0] cur_vec_r;
  reg [3:0] cur_lvl_r;

  reg win_found;
  reg [4:0] win_idx;
  reg [3:0] win_lvl;
  reg [`IEC_EXT-1:0] ext_hit;
  reg [31:0] rd_data;
  reg rd_err;
  integer k_win;
  integer k_edge;
  integer k_rst;

  wire setup_ph = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite & ~pslverr;
  wire node_sel = (paddr[11:7] == `IEC_A_NODE_HI);
  wire chan_sel = (paddr[11:7] == `IEC_A_CHAN_HI);
  wire [4:0] a_node = paddr[6:2];
  wire [2:0] a_ch = paddr[6:4];
  wire [1:0] a_fld = paddr[3:2];
  wire [2:0] cur_ch = chsel_r[cur_idx_r];
  wire cur_cont = cctl_r[cur_ch][`IEC_CC_CONT];
  wire cur_word = cctl_r[cur_ch][`IEC_CC_WORD];
  wire [`IEC_AW-1:0] cur_step = cur_word ? `IEC_STEP_WORD : `IEC_STEP_BYTE;
  // The count reaching zero is seen on the stolen cycle that takes it from one.
  wire zero_hit = (st_r == S_MOVE) & ~cur_cont & (cnt_r[cur_ch] == 8'h01);
  // A software trap is taken even during a hardware trap; node requests are held off.
  wire take_sw = (st_r == S_IDLE) & sw_trap_valid;
  wire take_node = (st_r == S_IDLE) & ~sw_trap_valid & win_found & ~trap_active;
  // An exhausted channel that is not continuous hands its node back to vectored service.
  wire w_chan_ok = (cnt_r[chsel_r[win_idx]] != 8'h00) | cctl_r[chsel_r[win_idx]][`IEC_CC_CONT];

  // Highest enabled pending level above the CPU level; lowest index wins ties.
  // Level 0 can never win, since it cannot exceed any CPU level.
  always @* begin
    win_found = 1'b0;
    win_idx = 5'd0;
    win_lvl = cpu_level;
    for (k_win = 0; k_win < `IEC_NODES; k_win = k_win + 1) begin
      if (req_r[k_win] & en_r[k_win] & (lvl_r[k_win] > win_lvl)) begin
        win_found = 1'b1;
        win_idx = k_win[4:0];
        win_lvl = lvl_r[k_win];
      end
    end
  end

  // Edge detection on the synchronised fast inputs.
  // Each pin has two select bits: rising in the even bit, falling in the odd one.
  always @* begin
    for (k_edge = 0; k_edge < `IEC_EXT; k_edge = k_edge + 1) begin
      ext_hit[k_edge] = (edge_sel_r[2*k_edge] & sync2_r[k_edge] & ~prev_r[k_edge]) |
                        (edge_sel_r[2*k_edge+1] & ~sync2_r[k_edge] & prev_r[k_edge]);
    end
  end

  // Request flags: pulse, pin and count-zero sets win over a clear in the same cycle; a bus write of one loses to the take.
  // Fast pins share the request flags of the first eight nodes.
  always @* begin
    req_nxt = req_r;
    if (wr_en & node_sel) begin
      req_nxt[a_node] = pwdata[`IEC_NC_REQ];
    end
    if (take_node) begin
      req_nxt[win_idx] = 1'b0;
    end
    req_nxt = req_nxt | node_req_pulse | {{(`IEC_NODES-`IEC_EXT){1'b0}}, ext_hit};
    if (zero_hit) begin
      req_nxt[cur_idx_r] = 1'b1;
    end
  end

  // Status bits are sticky; an event beats a write-one-clear in the same cycle.
  always @* begin
    sts_nxt = sts_r;
    if (wr_en & (paddr == `IEC_A_STATUS)) begin
      sts_nxt = sts_r & ~pwdata[`IEC_ST_W-1:0];
    end
    if (st_r == S_MOVE) begin
      sts_nxt[`IEC_ST_MOVE] = 1'b1;
    end
    if (zero_hit) begin
      sts_nxt[`IEC_ST_ZERO] = 1'b1;
    end
    if ((st_r == S_WAIT) & (wait_r == 3'd0) & ~cur_move_r) begin
      sts_nxt[`IEC_ST_VEC] = 1'b1;
    end
  end

  // Read mux, evaluated in the setup cycle.
  // Unmapped addresses answer with an error and read as zero.
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (node_sel) begin
      rd_data[`IEC_NC_LVL] = lvl_r[a_node];
      rd_data[`IEC_NC_CH] = chsel_r[a_node];
      rd_data[`IEC_NC_EVT] = evt_r[a_node];
      rd_data[`IEC_NC_EN] = en_r[a_node];
      rd_data[`IEC_NC_REQ] = req_r[a_node];
    end else if (chan_sel) begin
      case (a_fld)
        `IEC_CH_SRC: rd_data[`IEC_AW-1:0] = src_r[a_ch];
        `IEC_CH_DST: rd_data[`IEC_AW-1:0] = dst_r[a_ch];
        `IEC_CH_CNT: rd_data[7:0] = cnt_r[a_ch];
        default: rd_data[2:0] = cctl_r[a_ch];
      endcase
    end else if (paddr == `IEC_A_EDGE) begin
      rd_data[15:0] = edge_sel_r;
    end else if (paddr == `IEC_A_STATUS) begin
      rd_data[`IEC_ST_W-1:0] = sts_r;
    end else if (paddr == `IEC_A_MASK) begin
      rd_data[`IEC_ST_W-1:0] = mask_r;
    end else if (paddr == `IEC_A_CPU) begin
      rd_data[1:0] = st_r;
      rd_data[8:4] = cur_idx_r;
      rd_data[19:12] = {3'b000, irq_req, cur_lvl_r};
    end else begin
      rd_err = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      sync1_r <= {`IEC_EXT{1'b0}};
      sync2_r <= {`IEC_EXT{1'b0}};
      prev_r <= {`IEC_EXT{1'b0}};
    end else begin
      // The error flag stands only in the access cycle, next to pready.
      pready <= setup_ph;
      pslverr <= setup_ph & rd_err;
      if (setup_ph) begin
        prdata <= rd_data;
      end
      // The fast pins pass two flip-flops before the edge detector sees them.
      sync1_r <= ext_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Node and channel configuration, plus channel updates on a transfer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= {`IEC_NODES{1'b0}};
      en_r <= {`IEC_NODES{1'b0}};
      evt_r <= {`IEC_NODES{1'b0}};
      for (k_rst = 0; k_rst < `IEC_NODES; k_rst = k_rst + 1) begin
        lvl_r[k_rst] <= 4'h0;
        chsel_r[k_rst] <= 3'h0;
      end
      for (k_rst = 0; k_rst < `IEC_CHANS; k_rst = k_rst + 1) begin
        src_r[k_rst] <= 24'h00_0000;
        dst_r[k_rst] <= 24'h00_0000;
        cnt_r[k_rst] <= 8'h00;
        cctl_r[k_rst] <= 3'h0;
      end
      edge_sel_r <= 16'h0000;
      sts_r <= {`IEC_ST_W{1'b0}};
      mask_r <= {`IEC_ST_W{1'b0}};
      irq_out <= 1'b0;
    end else begin
      req_r <= req_nxt;
      sts_r <= sts_nxt;
      irq_out <= |(sts_r & mask_r);
      if (wr_en & node_sel) begin
        lvl_r[a_node] <= pwdata[`IEC_NC_LVL];
        chsel_r[a_node] <= pwdata[`IEC_NC_CH];
        evt_r[a_node] <= pwdata[`IEC_NC_EVT];
        en_r[a_node] <= pwdata[`IEC_NC_EN];
      end
      if (wr_en & chan_sel) begin
        case (a_fld)
          `IEC_CH_SRC: src_r[a_ch] <= pwdata[`IEC_AW-1:0];
          `IEC_CH_DST: dst_r[a_ch] <= pwdata[`IEC_AW-1:0];
          `IEC_CH_CNT: cnt_r[a_ch] <= pwdata[7:0];
          default: cctl_r[a_ch] <= pwdata[2:0];
        endcase
      end
      if (wr_en & (paddr == `IEC_A_EDGE)) begin
        edge_sel_r <= pwdata[15:0];
      end
      if (wr_en & (paddr == `IEC_A_MASK)) begin
        mask_r <= pwdata[`IEC_ST_W-1:0];
      end
      // A stolen cycle owns the pointer that it steps; a bus write to that pointer in that cycle loses.
      if (st_r == S_MOVE) begin
        if (cctl_r[cur_ch][`IEC_CC_INCDST]) begin
          dst_r[cur_ch] <= dst_r[cur_ch] + cur_step;
        end else begin
          src_r[cur_ch] <= src_r[cur_ch] + cur_step;
        end
        if (~cur_cont) begin
          cnt_r[cur_ch] <= cnt_r[cur_ch] - 8'h01;
        end
      end
    end
  end

  // Service engine: wait, then either steal one cycle or request a vector.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      wait_r <= 3'd0;
      cur_idx_r <= 5'd0;
      cur_move_r <= 1'b0;
      cur_vec_r <= 9'h000;
      cur_lvl_r <= 4'h0;
      irq_req <= 1'b0;
      irq_vector <= 9'h000;
      irq_level <= 4'h0;
      move_valid <= 1'b0;
      move_src <= 24'h00_0000;
      move_dst <= 24'h00_0000;
      move_word <= 1'b0;
    end else begin
      case (st_r)
        S_IDLE: begin
          // The wait counter is reloaded in every idle cycle, so each request sees one delay.
          wait_r <= `IEC_WAIT_CYC;
          // A software trap keeps the current CPU level, since it has no level of its own.
          if (take_sw) begin
            cur_move_r <= 1'b0;
            cur_vec_r <= vec_of(sw_trap_num);
            cur_lvl_r <= cpu_level;
            st_r <= S_WAIT;
          end else if (take_node) begin
            cur_idx_r <= win_idx;
            cur_move_r <= evt_r[win_idx] & w_chan_ok;
            cur_vec_r <= vec_of(trap_of(win_idx));
            cur_lvl_r <= win_lvl;
            st_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (wait_r != 3'd0) begin
            wait_r <= wait_r - 3'd1;
          end else if (cur_move_r) begin
            move_valid <= 1'b1;
            move_src <= src_r[cur_ch];
            move_dst <= dst_r[cur_ch];
            move_word <= cur_word;
            st_r <= S_MOVE;
          end else begin
            irq_req <= 1'b1;
            irq_vector <= cur_vec_r;
            irq_level <= cur_lvl_r;
            st_r <= S_REQ;
          end
        end
        // The vector stands until the CPU acknowledges it.
        S_REQ: begin
          if (irq_ack) begin
            irq_req <= 1'b0;
            st_r <= S_IDLE;
          end
        end
        // The selected pointer, and the counter unless continuous, step at this edge in the configuration process.
        S_MOVE: begin
          move_valid <= 1'b0;
          st_r <= S_IDLE;
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// file: src/iec_defines.vh
// Constants for the interrupt and event transfer controller.
`ifndef IEC_DEFINES_VH
`define IEC_DEFINES_VH

`define IEC_NODES 32
`define IEC_CHANS 8
`define IEC_EXT 8
`define IEC_AW 24

// Response time window in CPU clocks. Three waiting cycles after the take
// put the answer five clocks after the request flag is set.
`define IEC_RESP_MIN_CLK 5
`define IEC_RESP_MAX_CLK 12
`define IEC_WAIT_CYC 3'h3

// Trap number bases of the three node groups.
`define IEC_TRAP_BASE0 7'h10
`define IEC_TRAP_BASE1 7'h30
`define IEC_TRAP_BASE2 7'h44
`define IEC_GRP1_FIRST 5'd16
`define IEC_GRP2_FIRST 5'd29

// Node control register fields.
`define IEC_NC_LVL 3:0
`define IEC_NC_CH 6:4
`define IEC_NC_EVT 7
`define IEC_NC_EN 8
`define IEC_NC_REQ 9

// Channel control register fields.
`define IEC_CC_WORD 0
`define IEC_CC_INCDST 1
`define IEC_CC_CONT 2

// Status and mask bits.
`define IEC_ST_MOVE 0
`define IEC_ST_ZERO 1
`define IEC_ST_VEC 2
`define IEC_ST_W 3

// Register map, byte addresses.
`define IEC_A_NODE_HI 5'h00
`define IEC_A_CHAN_HI 5'h02
`define IEC_A_EDGE 12'h200
`define IEC_A_STATUS 12'h204
`define IEC_A_MASK 12'h208
`define IEC_A_CPU 12'h20C
`define IEC_CH_SRC 2'd0
`define IEC_CH_DST 2'd1
`define IEC_CH_CNT 2'd2
`define IEC_CH_CTL 2'd3

`define IEC_STEP_BYTE 24'h00_0001
`define IEC_STEP_WORD 24'h00_0002

`endif

// file: testbench/iec_cpu.sv
// Behavioural CPU side that accepts vectors after a chosen delay.
`timescale 1ns/10ps
module iec_cpu (
  input wire pclk,
  input wire presetn,
  input wire irq_req,
  input wire [3:0] ack_dly,
  output reg irq_ack
);
  reg [3:0] wait_r;
  // Acknowledge is held until the edge that sees it together with the request.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      wait_r <= 4'h0;
    end else if (irq_req && !irq_ack) begin
      wait_r <= wait_r + 4'h1;
      if (wait_r >= ack_dly) begin
        irq_ack <= 1'b1;
      end
    end else begin
      irq_ack <= 1'b0;
      wait_r <= 4'h0;
    end
  end
endmodule

// file: testbench/iec_chk.sv
// Port level assertions for the interrupt and event transfer controller.
`timescale 1ns/10ps
module iec_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire trap_active,
  input wire sw_trap_valid,
  input wire irq_ack,
  input wire irq_req,
  input wire [8:0] irq_vector,
  input wire move_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_move_pulse: assert property (move_valid |=> !move_valid) else $error("move too long");
  a_move_novec: assert property (move_valid |-> !irq_req) else $error("move with vector");
  a_req_hold: assert property (irq_req && !irq_ack |=> irq_req && $stable(irq_vector))
    else $error("vector request dropped");
  a_ack_drop: assert property (irq_req && irq_ack |=> !irq_req) else $error("request kept");
  a_vec_align: assert property (irq_req |-> irq_vector[1:0] == 2'b00)
    else $error("vector not aligned");
  a_trap_hold: assert property ((trap_active && !sw_trap_valid)[*6] |->
    !$rose(move_valid) && !$rose(irq_req)) else $error("service during trap");
endmodule

bind iec_top iec_chk u_iec_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .trap_active(trap_active),
  .sw_trap_valid(sw_trap_valid), .irq_ack(irq_ack), .irq_req(irq_req),
  .irq_vector(irq_vector), .move_valid(move_valid));

// file: testbench/tb_top.sv
// Self-checking bench for the interrupt and event transfer controller.
`timescale 1ns/10ps
module tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trap_active = 0;
  reg sw_trap_valid = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, node_req_pulse = 0, rd;
  reg [7:0] ext_pin = 0;
  reg [3:0] cpu_level = 4'hF, ack_dly = 0;
  reg [6:0] sw_trap_num = 0;
  reg er;
  wire [31:0] prdata;
  wire pready, pslverr, irq_ack, irq_req, move_valid, move_word, irq_out;
  wire [8:0] irq_vector;
  wire [3:0] irq_level;
  wire [23:0] move_src, move_dst;
  integer err_count = 0, n_compared = 0, cyc = 0, n_irq = 0, lat, k, i, s;
  integer nodes [0:5] = '{0, 15, 16, 28, 29, 31};
  iec_top u_iec_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .node_req_pulse(node_req_pulse), .ext_pin(ext_pin),
    .cpu_level(cpu_level), .trap_active(trap_active), .sw_trap_valid(sw_trap_valid),
    .sw_trap_num(sw_trap_num), .irq_ack(irq_ack), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level), .move_valid(move_valid),
    .move_src(move_src), .move_dst(move_dst), .move_word(move_word), .irq_out(irq_out));
  iec_cpu u_iec_cpu (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .ack_dly(ack_dly),
    .irq_ack(irq_ack));
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (irq_req && irq_ack) n_irq <= n_irq + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("[FAIL] %0s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task pulse(input [31:0] m);
    @(posedge pclk);
    node_req_pulse <= m;
    @(posedge pclk);
    node_req_pulse <= 0;
  endtask
  task wait_irq(input [8:0] v, input [3:0] l);
    lat = 0;
    while (irq_req !== 1'b1 && lat < 40) begin
      @(posedge pclk);
      lat = lat + 1;
    end
    chk("irq_req", 1, 32'(irq_req));
    chk("vector", 32'(v), 32'(irq_vector));
    chk("level", 32'(l), 32'(irq_level));
    while (irq_req === 1'b1) @(posedge pclk);
  endtask
  task wait_move(input [23:0] sa, input [23:0] da, input w);
    lat = 0;
    while (move_valid !== 1'b1 && lat < 40) begin
      @(posedge pclk);
      lat = lat + 1;
    end
    chk("move_valid", 1, 32'(move_valid));
    chk("src", 32'(sa), 32'(move_src));
    chk("dst", 32'(da), 32'(move_dst));
    chk("word", 32'(w), 32'(move_word));
  endtask
  task quiet;
    k = n_irq;
    repeat (20) @(posedge pclk);
    chk("irqs", k, n_irq);
  endtask
  task t_regs;
    apb(1, 12'h00C, 32'h0000_01FF);
    apb(0, 12'h00C, 0);
    chk("node", 32'h0000_01FF, rd);
    apb(0, 12'h300, 0);
    chk("err", 1, 32'(er));
    chk("rdata", 0, rd);
    apb(1, 12'h00C, 0);
  endtask
  task t_vec;
    cpu_level <= 0;
    for (i = 0; i < 6; i = i + 1) begin
      apb(1, 12'(nodes[i] * 4), 32'h0000_0305);
      s = nodes[i] < 16 ? 16 + nodes[i] : nodes[i] < 29 ? 32 + nodes[i] : 39 + nodes[i];
      wait_irq(9'(s * 4), 5);
      chk("resp", 1, 32'(lat >= 5 && lat <= 12));
    end
  endtask
  task t_prio;
    apb(1, 12'h008, 32'h0000_0103);
    apb(1, 12'h014, 32'h0000_0109);
    pulse(32'h0000_0024);
    wait_irq(9'h054, 9);
    wait_irq(9'h048, 3);
    cpu_level <= 9;
    pulse(32'h0000_0020);
    quiet;
    cpu_level <= 8;
    wait_irq(9'h054, 9);
    cpu_level <= 0;
  endtask
  task t_trap;
    ack_dly <= 7;
    trap_active <= 1;
    apb(1, 12'h004, 32'h0000_0304);
    quiet;
    sw_trap_num <= 7'h7F;
    sw_trap_valid <= 1;
    while (irq_req !== 1'b1) @(posedge pclk);
    sw_trap_valid <= 0;
    wait_irq(9'h1FC, 0);
    trap_active <= 0;
    wait_irq(9'h044, 4);
    ack_dly <= 0;
  endtask
  task t_move;
    apb(1, 12'h120, 32'h0000_1000);
    apb(1, 12'h124, 32'h0000_2000);
    apb(1, 12'h128, 32'h0000_0002);
    apb(1, 12'h12C, 32'h0000_0003);
    apb(1, 12'h018, 32'h0000_01A2);
    pulse(32'h0000_0040);
    wait_move(24'h00_1000, 24'h00_2000, 1);
    pulse(32'h0000_0040);
    wait_move(24'h00_1000, 24'h00_2002, 1);
    wait_irq(9'h058, 2);
    apb(0, 12'h128, 0);
    chk("count", 0, rd);
    chk("masked", 0, 32'(irq_out));
    apb(1, 12'h208, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk("irq_out", 1, 32'(irq_out));
    apb(1, 12'h204, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk("cleared", 0, 32'(irq_out));
    apb(1, 12'h130, 32'h0000_0500);
    apb(1, 12'h138, 32'h0000_0005);
    apb(1, 12'h13C, 32'h0000_0004);
    apb(1, 12'h01C, 32'h0000_01B2);
    pulse(32'h0000_0080);
    wait_move(24'h00_0500, 0, 0);
    pulse(32'h0000_0080);
    wait_move(24'h00_0501, 0, 0);
    apb(0, 12'h138, 0);
    chk("count", 5, rd);
  endtask
  task t_edge;
    apb(1, 12'h000, 32'h0000_0106);
    for (s = 1; s < 4; s = s + 1) begin
      apb(1, 12'h200, 32'(s));
      k = n_irq;
      @(posedge pclk);
      ext_pin[0] <= 1;
      repeat (20) @(posedge pclk);
      chk("rise", k + s % 2, n_irq);
      k = n_irq;
      ext_pin[0] <= 0;
      repeat (20) @(posedge pclk);
      chk("fall", k + s / 2, n_irq);
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_vec;
    t_prio;
    t_trap;
    t_move;
    t_edge;
    tally_and_finish;
  end
endmodule
